// ===== bench/osc_model.sv
// Purpose: Oscillator model giving a running level and one tick per period.
// Assumes: One tick every P_DIV clock cycles while enabled.
// Notes:   Stops dead when disabled, so no tick ever comes early.
`timescale 1ns/1ps
module osc_model #(parameter int P_DIV = 8) (
    input  wire logic i_clk,
    input  wire logic i_en,
    output logic      o_running,
    output logic      o_tick
);
    int cnt = 0;
    // Period divider
    always_ff @(posedge i_clk) begin
        cnt <= (i_en && cnt < P_DIV - 1) ? cnt + 1 : 0;
    end
    assign o_running = i_en;
    assign o_tick    = i_en && (cnt == P_DIV - 1);
endmodule

// ===== bench/reset_release_sequencer_tb_top.sv
// Purpose: Self-checking bench for the reset release sequencer.
// Assumes: Slow oscillator (8 cycles a period) so crystal start-up outlasts reset.
// Notes:   Hold times carry up to 99 cycles of tick phase slack.
`timescale 1ns/1ps
module reset_release_sequencer_tb_top;
    import reset_seq_pkg::*;
    localparam int POWER_UP_TIMER = 30;
    localparam int MON  = 5;
    logic i_clk = 0, i_rst_n = 0, i_power_on_reset = 0, i_brown_out_reset = 0, i_master_clear_pin = 0;
    logic i_watchdog_reset = 0, i_software_reset_instr = 0, i_illegal_opcode_reset = 0, i_trap_conflict_reset = 0;
    logic i_clock_switch_en = 1, i_primary_is_crystal = 1, i_regulator_en = 1, i_clock_fail_monitor_en = 0;
    logic i_wake_event = 0, i_sleep_entry = 0, i_idle_entry = 0, i_reset_control_wr = 0, osc_en = 1;
    logic [2:0]  i_config_osc_select = OSC_PRI;
    logic [15:0] i_reset_control_wdata = 16'h0000;
    logic i_osc_running, i_osc_tick, o_master_system_reset_n, o_cpu_run, o_pc_load, o_monitor_active, o_osc_fail_trap;
    logic [23:0] o_pc_value;
    logic [2:0]  o_current_osc_select;
    logic [15:0] o_oscillator_control_reg, o_reset_control_reg, rc_m;
    int n_errors = 0, tests_run = 0, cycles = 0, cur_m, n;
    int flag_bit[5] = '{RC_EXTR, RC_WDTO, RC_SWR, RC_IOPUWR, RC_TRAPR};

    osc_model #(.P_DIV(8)) OSC (.i_clk(i_clk), .i_en(osc_en), .o_running(i_osc_running), .o_tick(i_osc_tick));
    reset_release_sequencer #(.P_POWER_UP_TIMER_US(COUNT_W'(POWER_UP_TIMER)), .P_MONITOR_DELAY_US(COUNT_W'(MON))) DUT (.i_clk,
        .i_rst_n, .i_power_on_reset, .i_brown_out_reset, .i_master_clear_pin, .i_watchdog_reset,
        .i_software_reset_instr, .i_illegal_opcode_reset, .i_trap_conflict_reset, .i_clock_switch_en,
        .i_config_osc_select, .i_primary_is_crystal, .i_regulator_en, .i_clock_fail_monitor_en, .i_osc_running,
        .i_osc_tick, .i_wake_event, .i_sleep_entry, .i_idle_entry, .i_reset_control_wr, .i_reset_control_wdata,
        .o_master_system_reset_n, .o_cpu_run, .o_pc_load, .o_pc_value, .o_current_osc_select,
        .o_oscillator_control_reg, .o_reset_control_reg, .o_monitor_active, .o_osc_fail_trap);

    // Clock and hang guard
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hold length in cycles against a time in microseconds
    task automatic chk_len(input int got, input int us);
        tests_run++;
        if (got < us * 100 - 100 || got > us * 100 + 5) begin
            n_errors++;
            $display("ERROR %0t length %0d for %0d us", $time, got, us);
        end
    endtask
    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    // Cycles an output stays low: 0 master reset, 1 run
    task automatic low_len(input bit sel, output int k);
        k = 0;
        while ((sel ? o_cpu_run : o_master_system_reset_n) !== 1'b1 && k < 20000) begin
            @(negedge i_clk);
            k++;
        end
    endtask
    task automatic chk_osc();
        chk_val(o_current_osc_select, cur_m);
        chk_val(o_oscillator_control_reg, 24'(cur_m) << OSC_CURRENT_OSC_SELECT_LSB);
        chk_val(o_reset_control_reg, rc_m);
    endtask
    // Power-on through i_rst_n
    task automatic boot();
        int st;
        st = i_regulator_en ? STARTUP_REG_US : POWER_UP_TIMER;
        i_rst_n = 0;
        repeat (3) @(negedge i_clk);
        i_rst_n = 1;
        cur_m = i_config_osc_select;
        rc_m = RESET_CONTROL_REG_RESET;
        low_len(0, n);
        chk_len(n, POR_DELAY_US + st + TRST_US);
        chk_val(o_cpu_run, 1'b0);
    endtask
    // Source k: 0..4 flagged resets, 5 brown-out, 6 power-on
    task automatic run_case(input int k);
        int us;
        @(negedge i_clk);
        case (k)
            0: i_master_clear_pin = 1;
            1: i_watchdog_reset = 1;
            2: i_software_reset_instr = 1;
            3: i_illegal_opcode_reset = 1;
            4: i_trap_conflict_reset = 1;
            5: i_brown_out_reset = 1;
            default: i_power_on_reset = 1;
        endcase
        @(negedge i_clk);
        {i_master_clear_pin, i_watchdog_reset, i_software_reset_instr, i_illegal_opcode_reset} = '0;
        {i_trap_conflict_reset, i_brown_out_reset, i_power_on_reset} = '0;
        us = (k < 5) ? TRST_US : STARTUP_REG_US + TRST_US + ((k == 6) ? POR_DELAY_US : 0);
        if (k >= 5 || !i_clock_switch_en) cur_m = i_config_osc_select;
        if (k < 5) rc_m[flag_bit[k]] = 1'b1;
        else rc_m = (rc_m & ~((k == 5) ? RESET_CONTROL_REG_BOR_CLEAR : RESET_CONTROL_REG_POR_CLEAR)) | ((k == 5) ? 16'h0002 : 16'h0003);
        low_len(0, n);
        chk_len(n, us);
        low_len(1, n);
        chk_val(o_pc_load, 1'b1);
        chk_val(o_pc_value, RESET_VECTOR);
        chk_osc();
        $display("reset kind %0d done", k);
    endtask

    initial begin
        void'($urandom(32'h6143));
        boot();
        low_len(1, n);
        chk_val(o_pc_load, 1'b1);
        chk_osc();
        $display("crystal boot done");
        // Regulator off, PLL crystal, monitor finds no clock
        {i_regulator_en, i_clock_fail_monitor_en, i_config_osc_select} = {2'b01, OSC_PRIPLL};
        boot();
        n = 0;
        while (o_osc_fail_trap !== 1'b1 && n < 2000) begin
            @(negedge i_clk);
            n++;
        end
        chk_len(n, MON);
        chk_val(o_current_osc_select, OSC_FRC);
        chk_val(o_monitor_active, 1'b1);
        cur_m = OSC_FRC;
        {i_regulator_en, i_clock_fail_monitor_en} = 2'b10;
        $display("monitor trap done");
        for (int k = 0; k < 5; k++) begin
            i_config_osc_select = 3'($urandom_range(5));
            run_case(k);
        end
        i_clock_switch_en = 0;
        run_case(0);
        i_clock_switch_en = 1;
        i_config_osc_select = OSC_FRC;
        run_case(5);
        // Software write, sleep flag, then power-on clearing
        {i_reset_control_wr, i_reset_control_wdata} = {1'b1, 16'hffff};
        @(negedge i_clk);
        i_reset_control_wr = 0;
        i_sleep_entry = 1;
        @(negedge i_clk);
        i_sleep_entry = 0;
        rc_m = (RESET_CONTROL_REG_WR_MASK | 16'h0008) & ~16'h0010;
        @(negedge i_clk);
        chk_val(o_reset_control_reg, rc_m);
        run_case(6);
        // Wake with regulator on
        i_wake_event = 1;
        @(negedge i_clk);
        i_wake_event = 0;
        low_len(1, n);
        chk_len(n, STARTUP_REG_US);
        $display("wake done");
        summarize();
    end
endmodule

// ===== hdl/delay_timer.sv
// Purpose: Down-counter timing one delay in reference ticks.
// Assumes: load wins over counting; a zero count is never loaded.
// Notes:   busy stays high until the last tick has been counted.
`timescale 1ns/1ps
module delay_timer
    import reset_seq_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    delay_timer_if.timer tif
);
    logic [COUNT_W-1:0] cnt;

    // Reload or count down on each reference tick
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
        end else if (tif.load) begin
            cnt <= tif.count;
        end else if (tif.tick && cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign tif.busy = (cnt != '0);
endmodule

// ===== hdl/reset_release_sequencer.sv
// Purpose: Sequences master reset release, clock selection and code start after any reset.
// Assumes: Reset sources are synchronous active-high levels; i_rst_n is the power-on reset.
// Notes:   Delays but the oscillator start-up count are timed in 1 us reference ticks.
// How it works
// RL1: Switching on: POR/BOR use config, others keep
// RL2: Switching off: always use configured oscillator
// RL3: Hold reset until reset delays expire
// RL4: POR delay power-on plus start-up plus state
// RL5: Other resets wait internal state time only
// RL6: Start-up 20 us with regulator, else timer
// RL7: Wake with regulator applies start-up delay
// RL8: Crystal sources count 1024 oscillator periods
// RL9: PLL sources add lock after start-up count
// RL10: Clock delays run alongside reset delay
// RL11: Execute only once clock is released
// RL12: Monitor sees no clock: switch, raise trap
// RL13: Crystal or PLL: monitor waits extra delay
// RL14: Other registers ignore reset type
// RL15: Oscillator control value from type and config
// RL16: Any reset source asserts master reset
// RL17: Each reset sets its flag; POR clears
// RL18: Release clears PC to address zero
// RL19: Delays are down-counters on reference tick; the start-up count is an up-counter on oscillator ticks
`timescale 1ns/1ps
module reset_release_sequencer
    import reset_seq_pkg::*;
#(
    parameter logic [COUNT_W-1:0] P_POWER_UP_TIMER_US          = COUNT_W'(POWER_UP_TIMER_US),
    parameter logic [COUNT_W-1:0] P_MONITOR_DELAY_US = COUNT_W'(MONITOR_DELAY_US)
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_power_on_reset,
    input  wire logic        i_brown_out_reset,
    input  wire logic        i_master_clear_pin,
    input  wire logic        i_watchdog_reset,
    input  wire logic        i_software_reset_instr,
    input  wire logic        i_illegal_opcode_reset,
    input  wire logic        i_trap_conflict_reset,
    input  wire logic        i_clock_switch_en,
    input  wire logic [2:0]  i_config_osc_select,
    input  wire logic        i_primary_is_crystal,
    input  wire logic        i_regulator_en,
    input  wire logic        i_clock_fail_monitor_en,
    input  wire logic        i_osc_running,
    input  wire logic        i_osc_tick,
    input  wire logic        i_wake_event,
    input  wire logic        i_sleep_entry,
    input  wire logic        i_idle_entry,
    input  wire logic        i_reset_control_wr,
    input  wire logic [15:0] i_reset_control_wdata,
    output logic             o_master_system_reset_n,
    output logic             o_cpu_run,
    output logic             o_pc_load,
    output logic [23:0]      o_pc_value,
    output logic [2:0]       o_current_osc_select,
    output logic [15:0]      o_oscillator_control_reg,
    output logic [15:0]      o_reset_control_reg,
    output logic             o_monitor_active,
    output logic             o_osc_fail_trap
);
    typedef enum logic [1:0] {ST_HOLD, ST_RELEASED, ST_WAKE} seq_state_t;
    typedef enum logic [1:0] {CK_OST, CK_LOCK, CK_READY} clk_state_t;

    seq_state_t         state;
    clk_state_t         ck_state;
    reset_kind_t        kind;
    reset_kind_t        next_kind;
    logic               boot;
    logic               por_now;
    logic               any_src;
    logic [TICK_W-1:0]  tick_cnt;
    logic               tick;
    logic [COUNT_W-1:0] startup_us;
    logic [COUNT_W-1:0] sys_count;
    logic [2:0]         next_current_osc_select;
    logic [OST_W-1:0]   ost_cnt;
    logic               release_now;
    logic               wake_start;
    logic               mon_wait;
    logic               mon_start;
    logic               fail_now;
    logic               ran;
    logic [15:0]        next_reset_control_reg;

    delay_timer_if sys_if ();
    delay_timer_if lock_if ();
    delay_timer_if mon_if ();

    delay_timer u_sys_timer  (.i_clk(i_clk), .i_rst_n(i_rst_n), .tif(sys_if));
    delay_timer u_lock_timer (.i_clk(i_clk), .i_rst_n(i_rst_n), .tif(lock_if));
    delay_timer u_mon_timer  (.i_clk(i_clk), .i_rst_n(i_rst_n), .tif(mon_if));

    // The first cycle after power-up acts as a power-on reset source
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            boot <= 1'b1;
        end else begin
            boot <= 1'b0;
        end
    end

    // Source combining and classification
    assign por_now = i_power_on_reset | boot;
    assign any_src = por_now | i_brown_out_reset | i_master_clear_pin | i_watchdog_reset
                   | i_software_reset_instr | i_illegal_opcode_reset | i_trap_conflict_reset; // [RL16]
    assign next_kind = por_now ? KIND_POR : (i_brown_out_reset ? KIND_BOR : KIND_OTHER);

    // Free-running 1 us reference tick
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end
    assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1)); // [RL19]

    // Reset delay per reset type and regulator state
    always_comb begin
        startup_us = i_regulator_en ? COUNT_W'(STARTUP_REG_US) : P_POWER_UP_TIMER_US; // [RL6]
        case (next_kind)
            KIND_POR: sys_count = COUNT_W'(POR_DELAY_US) + startup_us + COUNT_W'(TRST_US); // [RL4]
            KIND_BOR: sys_count = startup_us + COUNT_W'(TRST_US); // [RL4]
            default:  sys_count = COUNT_W'(TRST_US); // [RL5]
        endcase
        if (!any_src) begin
            sys_count = COUNT_W'(STARTUP_REG_US);
        end
    end

    assign wake_start  = (state == ST_RELEASED) && i_wake_event && i_regulator_en; // [RL7]
    assign release_now = (state == ST_HOLD) && !any_src && !sys_if.busy;
    assign sys_if.load  = any_src || wake_start;
    assign sys_if.count = sys_count;
    assign sys_if.tick  = tick;

    // Main release sequence
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_HOLD;
        end else if (any_src) begin
            state <= ST_HOLD; // [RL16]
        end else begin
            case (state)
                ST_HOLD:     if (release_now) state <= ST_RELEASED; // [RL3]
                ST_RELEASED: if (wake_start) state <= ST_WAKE;
                ST_WAKE:     if (!sys_if.busy) state <= ST_RELEASED; // [RL7]
                default:     state <= ST_HOLD;
            endcase
        end
    end

    // Master reset output, low from any source until the delay has run out
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_master_system_reset_n <= 1'b0;
        end else if (any_src) begin
            o_master_system_reset_n <= 1'b0; // [RL16]
        end else if (release_now) begin
            o_master_system_reset_n <= 1'b1; // [RL3]
        end
    end

    // Latch the reset type seen while sources are active
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            kind <= KIND_POR;
        end else if (any_src) begin
            kind <= next_kind;
        end
    end

    // Oscillator choice at reset
    always_comb begin
        next_current_osc_select = o_current_osc_select;
        if (any_src && (!i_clock_switch_en || next_kind != KIND_OTHER)) begin
            next_current_osc_select = i_config_osc_select; // [RL1] [RL2]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_current_osc_select <= OSC_FRC;
        end else if (fail_now) begin
            o_current_osc_select <= OSC_FRC; // [RL12]
        end else begin
            o_current_osc_select <= next_current_osc_select; // [RL1] [RL15]
        end
    end
    assign o_oscillator_control_reg = 16'(o_current_osc_select) << OSC_CURRENT_OSC_SELECT_LSB; // [RL15]

    // Clock delays, started with the reset delay so both run together
    assign lock_if.load = (any_src && next_kind != KIND_OTHER && !needs_ost(next_current_osc_select, i_primary_is_crystal)
                           && needs_lock(next_current_osc_select))
                        || (ck_state == CK_OST && i_osc_running && i_osc_tick && ost_cnt == OST_LAST
                           && needs_lock(o_current_osc_select)); // [RL9] [RL10]
    assign lock_if.count = COUNT_W'(LOCK_US);
    assign lock_if.tick  = tick;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ck_state <= CK_OST;
            ost_cnt  <= '0;
        end else if (any_src) begin
            ost_cnt <= '0;
            if (next_kind == KIND_OTHER) begin
                ck_state <= CK_READY; // [RL5]
            end else if (needs_ost(next_current_osc_select, i_primary_is_crystal)) begin
                ck_state <= CK_OST; // [RL10]
            end else if (needs_lock(next_current_osc_select)) begin
                ck_state <= CK_LOCK; // [RL10]
            end else begin
                ck_state <= CK_READY;
            end
        end else if (fail_now) begin
            ck_state <= CK_READY; // [RL12]
        end else begin
            case (ck_state)
                CK_OST: begin
                    if (i_osc_running && i_osc_tick) begin
                        ost_cnt <= ost_cnt + 1'b1; // [RL8]
                        if (ost_cnt == OST_LAST) begin
                            ck_state <= needs_lock(o_current_osc_select) ? CK_LOCK : CK_READY; // [RL9]
                        end
                    end
                end
                CK_LOCK: if (!lock_if.busy && !lock_if.load) ck_state <= CK_READY; // [RL9]
                CK_READY: ck_state <= CK_READY;
                default:  ck_state <= CK_READY;
            endcase
        end
    end

    // Clock monitor start, delayed for crystal and PLL sources after POR or BOR
    assign mon_if.load  = release_now && kind != KIND_OTHER
                        && (needs_ost(o_current_osc_select, i_primary_is_crystal)
                            || needs_lock(o_current_osc_select)); // [RL13]
    assign mon_if.count = P_MONITOR_DELAY_US;
    assign mon_if.tick  = tick;
    assign mon_start    = (release_now && !mon_if.load) || (mon_wait && !mon_if.busy);
    assign fail_now     = mon_start && i_clock_fail_monitor_en && ck_state != CK_READY; // [RL12]

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mon_wait         <= 1'b0;
            o_monitor_active <= 1'b0;
            o_osc_fail_trap  <= 1'b0;
        end else begin
            o_osc_fail_trap <= fail_now && !any_src;
            if (any_src) begin
                mon_wait         <= 1'b0;
                o_monitor_active <= 1'b0;
            end else if (mon_if.load) begin
                mon_wait <= 1'b1; // [RL13]
            end else if (mon_start) begin
                mon_wait         <= 1'b0;
                o_monitor_active <= i_clock_fail_monitor_en;
            end
        end
    end

    // Code runs only with reset released and a valid clock
    assign o_cpu_run = (state == ST_RELEASED) && (ck_state == CK_READY) && !any_src; // [RL11]
    assign o_pc_load = o_cpu_run && !ran; // [RL18]

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ran        <= 1'b0;
            o_pc_value <= RESET_VECTOR;
        end else if (any_src) begin
            ran        <= 1'b0;
            o_pc_value <= RESET_VECTOR; // [RL14] [RL18]
        end else if (o_pc_load) begin
            ran <= 1'b1;
        end
    end

    // Reset flags: software write, then type-specific clears, then sets win
    always_comb begin
        next_reset_control_reg = o_reset_control_reg;
        if (i_reset_control_wr) begin
            next_reset_control_reg = i_reset_control_wdata & RESET_CONTROL_REG_WR_MASK;
        end
        if (i_sleep_entry || i_idle_entry) begin
            next_reset_control_reg[RC_WDTO] = 1'b0;
        end
        if (por_now) begin
            next_reset_control_reg = next_reset_control_reg & ~RESET_CONTROL_REG_POR_CLEAR; // [RL17]
        end else if (i_brown_out_reset) begin
            next_reset_control_reg = next_reset_control_reg & ~RESET_CONTROL_REG_BOR_CLEAR;
        end
        next_reset_control_reg[RC_POR]    = next_reset_control_reg[RC_POR] | por_now; // [RL17]
        next_reset_control_reg[RC_BOR]    = next_reset_control_reg[RC_BOR] | por_now | i_brown_out_reset;
        next_reset_control_reg[RC_EXTR]   = next_reset_control_reg[RC_EXTR] | i_master_clear_pin;
        next_reset_control_reg[RC_SWR]    = next_reset_control_reg[RC_SWR] | i_software_reset_instr;
        next_reset_control_reg[RC_WDTO]   = next_reset_control_reg[RC_WDTO] | i_watchdog_reset;
        next_reset_control_reg[RC_SLEEP]  = next_reset_control_reg[RC_SLEEP] | i_sleep_entry;
        next_reset_control_reg[RC_IDLE]   = next_reset_control_reg[RC_IDLE] | i_idle_entry;
        next_reset_control_reg[RC_IOPUWR] = next_reset_control_reg[RC_IOPUWR] | i_illegal_opcode_reset;
        next_reset_control_reg[RC_TRAPR]  = next_reset_control_reg[RC_TRAPR] | i_trap_conflict_reset;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reset_control_reg <= RESET_CONTROL_REG_RESET;
        end else begin
            o_reset_control_reg <= next_reset_control_reg; // [RL17]
        end
    end

    // Cycles spent in the delay after the last source went away
    logic [23:0] hold_cycles;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_cycles <= '0;
        end else if (any_src || o_master_system_reset_n) begin
            hold_cycles <= '0;
        end else if (hold_cycles != 24'hffffff) begin
            hold_cycles <= hold_cycles + 1'b1;
        end
    end

    localparam int TRST_MIN_CYCLES = (TRST_US - 1) * TICK_CYCLES;

    sequence s_only_pin;
        i_master_clear_pin && !por_now && !i_brown_out_reset;
    endsequence

    sequence s_run_begins;
        o_cpu_run && !ran;
    endsequence

    a_src_resets_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL16]
        any_src |=> !o_master_system_reset_n) else $error("reset source did not assert master reset");

    a_trst_hold_time: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL3] [RL5]
        $rose(o_master_system_reset_n) |-> hold_cycles >= TRST_MIN_CYCLES)
        else $error("master reset released too early");

    a_run_needs_clock: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL11]
        o_cpu_run |-> o_master_system_reset_n && ck_state == CK_READY)
        else $error("code ran without a valid clock");

    a_por_flags_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL17]
        (por_now && !i_trap_conflict_reset && !i_illegal_opcode_reset && !i_reset_control_wr)
        |=> !o_reset_control_reg[RC_TRAPR] && !o_reset_control_reg[RC_IOPUWR] && o_reset_control_reg[RC_POR])
        else $error("power-on reset flags wrong");

    a_swr_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL17]
        i_software_reset_instr |=> o_reset_control_reg[RC_SWR]) else $error("software reset flag not set");

    a_osc_pin_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL1]
        (s_only_pin and i_clock_switch_en) |=> $stable(o_current_osc_select))
        else $error("pin reset changed oscillator");

    a_osc_config_load: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL1] [RL2]
        (any_src && (!i_clock_switch_en || por_now)) |=> o_current_osc_select == $past(i_config_osc_select))
        else $error("oscillator not loaded from config");

    a_fail_to_frc: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL12]
        o_osc_fail_trap |-> o_current_osc_select == OSC_FRC && o_cpu_run)
        else $error("clock fail did not switch to fast RC");

    a_wake_stalls: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL7]
        (wake_start && !any_src) |=> !o_cpu_run [*8]) else $error("wake did not apply start-up delay");

    // The program counter load is a single pulse at the reset vector
    a_pc_from_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL18]
        s_run_begins |-> o_pc_value == RESET_VECTOR ##1 !o_pc_load)
        else $error("code start not at reset vector");

endmodule

// ===== shared/delay_timer_if.sv
// Purpose: Carries load, count, tick and status between sequencer and a delay timer.
// Assumes: One clock domain.
`timescale 1ns/1ps
interface delay_timer_if;
    import reset_seq_pkg::*;
    logic               load;
    logic [COUNT_W-1:0] count;
    logic               tick;
    logic               busy;
    modport ctrl  (output load, count, tick, input busy);
    modport timer (input load, count, tick, output busy);
endinterface

// ===== shared/reset_seq_pkg.sv
// Purpose: Constants, encodings and helpers shared by the reset release sequencer.
// Assumes: 100 MHz clock; all delays but the oscillator start-up count timed in 1 us ticks from a divider.
// Notes:   Oscillator select encodings are local to this block.
package reset_seq_pkg;

    // Clock and reference tick
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 7;

    // Nominal delays, in microseconds
    localparam int POR_DELAY_US      = 10;
    localparam int STARTUP_REG_US    = 20;
    localparam int POWER_UP_TIMER_US           = 64000;
    localparam int TRST_US           = 20;
    localparam int LOCK_US           = 20;
    localparam int MONITOR_DELAY_US  = 100;

    // Delay counter width, in bits
    localparam int COUNT_W = 17;

    // Oscillator start-up counter: 1024 periods on a 10-bit counter
    localparam int OST_W = 10;
    localparam logic [OST_W-1:0] OST_LAST = 10'h3ff;

    // Oscillator select encodings
    localparam logic [2:0] OSC_FRC    = 3'h0;
    localparam logic [2:0] OSC_FRCPLL = 3'h1;
    localparam logic [2:0] OSC_PRI    = 3'h2;
    localparam logic [2:0] OSC_PRIPLL = 3'h3;
    localparam logic [2:0] OSC_SECONDARY_OSC   = 3'h4;
    localparam logic [2:0] OSC_LOW_POWER_INTERNAL_RC   = 3'h5;

    // Oscillator control register layout
    localparam int OSC_CURRENT_OSC_SELECT_LSB = 12;

    // Reset control register layout and values
    localparam int RC_TRAPR  = 15;
    localparam int RC_IOPUWR = 14;
    localparam int RC_EXTR   = 7;
    localparam int RC_SWR    = 6;
    localparam int RC_WDTO   = 4;
    localparam int RC_SLEEP  = 3;
    localparam int RC_IDLE   = 2;
    localparam int RC_BOR    = 1;
    localparam int RC_POR    = 0;
    localparam logic [15:0] RESET_CONTROL_REG_RESET      = 16'h0003;
    localparam logic [15:0] RESET_CONTROL_REG_WR_MASK    = 16'hc1ff;
    localparam logic [15:0] RESET_CONTROL_REG_POR_CLEAR  = 16'hc0de;
    localparam logic [15:0] RESET_CONTROL_REG_BOR_CLEAR  = 16'hc05c;

    // Program counter reset vector
    localparam logic [23:0] RESET_VECTOR = 24'h000000;

    typedef enum logic [1:0] {KIND_POR, KIND_BOR, KIND_OTHER} reset_kind_t;

    // Sources that need the oscillator start-up count
    function automatic logic needs_ost(input logic [2:0] sel, input logic xtal);
        needs_ost = (sel == OSC_SECONDARY_OSC) || (xtal && (sel == OSC_PRI || sel == OSC_PRIPLL));
    endfunction

    // Sources that need the PLL lock time
    function automatic logic needs_lock(input logic [2:0] sel);
        needs_lock = (sel == OSC_FRCPLL) || (sel == OSC_PRIPLL);
    endfunction

endpackage
